// ### rtl/msm_local_unit.sv
// local interrupt unit of the bootstrap processor: registers and message sender
// What this block does
// - identifier read back in the top byte
// - unit enabled only by bit 8, reset zero
// - error entry low byte is the vector
// - startup vector times 4 KByte is start address
// - init command word broadcasts init to others
// - startup command word broadcasts startup with vector
// - about 10 ms between init and startup
// - 200 us after each of two startups
// - woken processor fetches at the carried vector
// - halted processor waits for an init
// - count set to one, 100 ms presence timer
// - unit registers mapped strong uncacheable first
// - distinct management base per processor
// - 32-bit id by register read, 8-bit by load
// - leaf one reports initial id bits 31:24
// - leaf eleven reports full 32-bit id
// - bits 2:1 package, 4:3 cluster, 0 thread
// - without multithreading bit 0 is zero
// - old format: bits 1:0 socket, 3:2 cluster
// - initial id respects field boundaries
// - semaphore cleared, count raised under the lock
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module msm_local_unit #(
  parameter int INIT_GAP_CYC = msm_pkg::INIT_GAP_CYC,
  parameter int PRESENCE_CYC = msm_pkg::PRESENCE_CYC,
  parameter bit MULTITHREAD = 1'b1,
  parameter bit OLD_FORMAT = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // identifier straps and mode
  input wire logic [1:0] strap_package_i,
  input wire logic [1:0] strap_cluster_i,
  input wire logic strap_thread_i,
  input wire logic reg_iface_mode_i,
  // status and identification
  output logic unit_enabled_o,
  output logic [7:0] error_vector_o,
  output logic [7:0] ident_leaf1_id_o,
  output logic [31:0] ident_leaf11_id_o,
  output logic [31:0] model_reg_id_o,
  output logic [1:0] pkg_field_o,
  output logic [1:0] cluster_field_o,
  output logic thread_field_o,
  // message link
  msm_link_if.unit link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int TMR_W_L = msm_pkg::TMR_W;
  localparam logic [TMR_W_L-1:0] INIT_GAP = TMR_W_L'(INIT_GAP_CYC);
  localparam logic [TMR_W_L-1:0] START_GAP = TMR_W_L'(msm_pkg::START_GAP_CYC);
  localparam logic [TMR_W_L-1:0] PRESENCE = TMR_W_L'(PRESENCE_CYC);

  logic [7:0] id_q;
  logic id_taken_q;
  logic [31:0] spur_q;
  logic [31:0] cmd_q;
  logic [31:0] err_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] mreg_q;
  logic [TMR_W_L-1:0] gap_q;
  logic pend_q;
  logic [7:0] pend_vec_q;
  logic msg_valid_q;
  msm_pkg::msm_msg_t msg_kind_q;
  logic [7:0] msg_vec_q;
  logic [7:0] cnt_q;
  logic [TMR_W_L-1:0] tmr_q;
  logic run_q;
  logic none_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic [31:0] bmask;
  logic [31:0] cmd_new;
  logic is_init;
  logic is_start;
  logic send_init;
  logic send_start_now;
  logic send_pend;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_mask
      assign bmask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
    end
  endgenerate

  assign cmd_new = (cmd_q & ~bmask) | (wb_dat_i & bmask);
  assign is_init = wr && (wb_adr_i == msm_pkg::ADR_CMD_LOW) && spur_q[msm_pkg::UNIT_EN_BIT]
    && (cmd_new[31:8] == msm_pkg::CMD_INIT_HI) && (cmd_new[7:0] == msm_pkg::CMD_INIT_LO);
  assign is_start = wr && (wb_adr_i == msm_pkg::ADR_CMD_LOW) && spur_q[msm_pkg::UNIT_EN_BIT]
    && (cmd_new[31:8] == msm_pkg::CMD_START_HI);
  assign send_init = is_init;
  assign send_start_now = is_start && !pend_q && (gap_q == '0);
  assign send_pend = !is_init && !is_start && pend_q && (gap_q == '0);

  // ----------------------------------------------------------------
  // identifier caught once after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      id_q <= 8'h00;
      id_taken_q <= 1'b0;
    end else if (!id_taken_q) begin
      id_taken_q <= 1'b1;
      if (OLD_FORMAT) begin
        id_q <= {4'h0, strap_cluster_i, strap_package_i};
      end else begin
        id_q <= {3'b000, strap_cluster_i, strap_package_i,
                 MULTITHREAD ? strap_thread_i : 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mreg_q <= 32'h0000_0000;
    end else begin
      mreg_q <= reg_iface_mode_i ? {24'h00_0000, id_q} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spur_q <= msm_pkg::RST_SPUR_VEC;
      cmd_q <= msm_pkg::RST_CMD_LOW;
      err_q <= msm_pkg::RST_ERR_VEC;
    end else if (wr) begin
      unique case (wb_adr_i)
        msm_pkg::ADR_SPUR_VEC: spur_q <= (spur_q & ~bmask) | (wb_dat_i & bmask);
        msm_pkg::ADR_CMD_LOW: cmd_q <= cmd_new;
        msm_pkg::ADR_ERR_VEC: err_q <= (err_q & ~bmask) | (wb_dat_i & bmask);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req && !wb_we_i) begin
        unique case (wb_adr_i)
          msm_pkg::ADR_PROC_ID: dat_q <= {id_q, 24'h00_0000} & msm_pkg::ID_BYTE_MASK;
          msm_pkg::ADR_SPUR_VEC: dat_q <= spur_q;
          msm_pkg::ADR_CMD_LOW: dat_q <= cmd_q;
          msm_pkg::ADR_ERR_VEC: dat_q <= err_q;
          msm_pkg::ADR_BOOT_STAT: dat_q <= {21'h00_0000, run_q, none_q, pend_q, cnt_q};
          default: dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // message pacing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_q <= '0;
      pend_q <= 1'b0;
      pend_vec_q <= 8'h00;
      msg_valid_q <= 1'b0;
      msg_kind_q <= msm_pkg::MSM_MSG_INIT;
      msg_vec_q <= 8'h00;
    end else begin
      msg_valid_q <= 1'b0;
      if (send_init) begin
        msg_valid_q <= 1'b1;
        msg_kind_q <= msm_pkg::MSM_MSG_INIT;
        msg_vec_q <= 8'h00;
        gap_q <= INIT_GAP;
        pend_q <= 1'b0;
      end else if (send_start_now || send_pend) begin
        msg_valid_q <= 1'b1;
        msg_kind_q <= msm_pkg::MSM_MSG_STARTUP;
        msg_vec_q <= send_pend ? pend_vec_q : cmd_new[7:0];
        gap_q <= START_GAP;
        pend_q <= 1'b0;
      end else begin
        if (is_start) begin
          pend_q <= 1'b1;
          pend_vec_q <= cmd_new[7:0];
        end
        if (gap_q != '0) begin
          gap_q <= gap_q - 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // processor count and presence timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      tmr_q <= '0;
      run_q <= 1'b0;
      none_q <= 1'b0;
    end else if (send_init) begin
      cnt_q <= 8'h01;
      tmr_q <= PRESENCE;
      run_q <= 1'b1;
      none_q <= 1'b0;
    end else begin
      if (link.present && cnt_q != 8'hff) begin
        cnt_q <= cnt_q + 8'h01;
      end
      if (run_q) begin
        tmr_q <= tmr_q - 1'b1;
        if (tmr_q == TMR_W_L'(1)) begin
          run_q <= 1'b0;
          none_q <= (cnt_q == 8'h01) && !link.present;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign unit_enabled_o = spur_q[msm_pkg::UNIT_EN_BIT];
  assign error_vector_o = err_q[7:0];
  assign ident_leaf1_id_o = id_q;
  assign ident_leaf11_id_o = {24'h00_0000, id_q};
  assign model_reg_id_o = mreg_q;
  assign pkg_field_o = OLD_FORMAT ? id_q[msm_pkg::OLD_SOCK_LSB +: 2] : id_q[msm_pkg::ID_PKG_LSB +: 2];
  assign cluster_field_o = OLD_FORMAT ? id_q[msm_pkg::OLD_CLU_LSB +: 2] : id_q[msm_pkg::ID_CLU_LSB +: 2];
  assign thread_field_o = OLD_FORMAT ? 1'b0 : id_q[msm_pkg::ID_THREAD_LSB];
  assign link.msg_valid = msg_valid_q;
  assign link.msg_kind = msg_kind_q;
  assign link.msg_vector = msg_vec_q;

endmodule : msm_local_unit

// ### rtl/msm_pkg.sv
// shared constants and types for the startup messaging unit and its peers
package msm_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADR_PROC_ID = 32'hfee0_0020;
  localparam logic [31:0] ADR_SPUR_VEC = 32'hfee0_00f0;
  localparam logic [31:0] ADR_CMD_LOW = 32'hfee0_0300;
  localparam logic [31:0] ADR_ERR_VEC = 32'hfee0_0370;
  localparam logic [31:0] ADR_BOOT_STAT = 32'hfee0_03f0;

  // ----------------------------------------------------------------
  // field layouts and values after reset
  // ----------------------------------------------------------------
  localparam int UNIT_EN_BIT = 8;
  localparam logic [31:0] ID_BYTE_MASK = 32'hff00_0000;
  localparam logic [31:0] ERR_KEEP_MASK = 32'hffff_ff00;
  localparam logic [31:0] RST_SPUR_VEC = 32'h0000_0000;
  localparam logic [31:0] RST_CMD_LOW = 32'h0000_0000;
  localparam logic [31:0] RST_ERR_VEC = 32'h0000_0000;
  localparam logic [23:0] CMD_INIT_HI = 24'h00_0c45;
  localparam logic [7:0] CMD_INIT_LO = 8'h00;
  localparam logic [23:0] CMD_START_HI = 24'h00_0c46;
  localparam int PAGE_SHIFT = 12;
  localparam int STAT_PEND_BIT = 8;
  localparam int STAT_NONE_BIT = 9;
  localparam int STAT_RUN_BIT = 10;
  localparam int ID_THREAD_LSB = 0;
  localparam int ID_PKG_LSB = 1;
  localparam int ID_CLU_LSB = 3;
  localparam int OLD_SOCK_LSB = 0;
  localparam int OLD_CLU_LSB = 2;
  localparam logic [31:0] SMM_BASE0 = 32'h0003_0000;
  localparam logic [31:0] SMM_STRIDE = 32'h0000_8000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int INIT_GAP_MS = 10;
  localparam int START_GAP_US = 200;
  localparam int PRESENCE_MS = 100;
  localparam int INIT_GAP_CYC = INIT_GAP_MS * (CLK_HZ / 1000);
  localparam int START_GAP_CYC = START_GAP_US * (CLK_HZ / 1_000_000);
  localparam int PRESENCE_CYC = PRESENCE_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 20;

  // ----------------------------------------------------------------
  // message kinds on the link
  // ----------------------------------------------------------------
  typedef enum logic {
    MSM_MSG_INIT = 1'b0,
    MSM_MSG_STARTUP = 1'b1
  } msm_msg_t;

endpackage : msm_pkg

// ### rtl/msm_link_if.sv
// broadcast message link between the local unit and the peer processors
`timescale 1ns/1ps
interface msm_link_if;
  logic msg_valid;
  msm_pkg::msm_msg_t msg_kind;
  logic [7:0] msg_vector;
  logic present;

  modport unit (output msg_valid, output msg_kind, output msg_vector, input present);
  modport peers (input msg_valid, input msg_kind, input msg_vector, output present);
endinterface : msm_link_if

// ### rtl/msm_peer_procs.sv
// application processors that receive init and startup messages
`timescale 1ns/1ps
module msm_peer_procs #(
  parameter int NUM_AP = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // message link
  msm_link_if.peers link,
  // per-processor status
  output logic [NUM_AP-1:0] running_o,
  output logic [NUM_AP-1:0] halted_o,
  output logic [NUM_AP-1:0] uncached_map_o,
  output logic [NUM_AP-1:0][19:0] fetch_addr_o,
  output logic [NUM_AP-1:0][31:0] smm_base_o
);

  localparam int IW = (NUM_AP > 1) ? $clog2(NUM_AP) : 1;

  typedef enum logic [1:0] {
    AP_WAIT_START = 2'b00,
    AP_RUN = 2'b01,
    AP_LOCKED = 2'b10,
    AP_HALT = 2'b11
  } msm_ap_state_t;

  msm_ap_state_t st_q [NUM_AP];
  logic sem_busy_q;
  logic [IW-1:0] sem_owner_q;
  logic present_q;
  logic got_init;
  logic got_start;
  logic any_req;
  logic [IW-1:0] pick;
  logic any_locked;

  assign got_init = link.msg_valid && (link.msg_kind == msm_pkg::MSM_MSG_INIT);
  assign got_start = link.msg_valid && (link.msg_kind == msm_pkg::MSM_MSG_STARTUP);

  // ----------------------------------------------------------------
  // lowest waiting processor wins the semaphore
  // ----------------------------------------------------------------
  always_comb begin
    any_req = 1'b0;
    pick = '0;
    any_locked = 1'b0;
    for (int i = NUM_AP - 1; i >= 0; i--) begin
      if (st_q[i] == AP_RUN) begin
        any_req = 1'b1;
        pick = IW'(i);
      end
      if (st_q[i] == AP_LOCKED) begin
        any_locked = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sem_busy_q <= 1'b0;
      sem_owner_q <= '0;
      present_q <= 1'b0;
    end else begin
      present_q <= any_locked && !got_init;
      if (got_init) begin
        sem_busy_q <= 1'b0;
      end else if (any_locked) begin
        sem_busy_q <= 1'b0;
      end else if (!sem_busy_q && any_req) begin
        sem_busy_q <= 1'b1;
        sem_owner_q <= pick;
      end
    end
  end

  // ----------------------------------------------------------------
  // one state machine per processor
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_AP; g++) begin : g_ap
      logic [19:0] fetch_q;
      logic uc_q;
      logic [31:0] smm_q;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          st_q[g] <= AP_WAIT_START;
          fetch_q <= 20'h0_0000;
          uc_q <= 1'b0;
        end else if (got_init) begin
          st_q[g] <= AP_WAIT_START;
          uc_q <= 1'b0;
        end else begin
          unique case (st_q[g])
            AP_WAIT_START: begin
              if (got_start) begin
                fetch_q <= {link.msg_vector, 12'h000};
                uc_q <= 1'b1;
                st_q[g] <= AP_RUN;
              end
            end
            AP_RUN: begin
              if (sem_busy_q && sem_owner_q == IW'(g)) begin
                st_q[g] <= AP_LOCKED;
              end
            end
            AP_LOCKED: st_q[g] <= AP_HALT;
            AP_HALT: ;
          endcase
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          smm_q <= msm_pkg::SMM_BASE0 + 32'(g) * msm_pkg::SMM_STRIDE;
        end else begin
          smm_q <= smm_q;
        end
      end

      assign running_o[g] = (st_q[g] == AP_RUN) || (st_q[g] == AP_LOCKED);
      assign halted_o[g] = (st_q[g] == AP_HALT);
      assign uncached_map_o[g] = uc_q;
      assign fetch_addr_o[g] = fetch_q;
      assign smm_base_o[g] = smm_q;
    end
  endgenerate

  assign link.present = present_q;

endmodule : msm_peer_procs

// ### tb/msm_link_asserts.sv
// link protocol checker for the startup messaging unit and its peers
`timescale 1ns/1ps
module msm_link_asserts #(
  parameter int INIT_GAP = 50
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link signals
  input wire logic msg_valid,
  input wire msm_pkg::msm_msg_t msg_kind,
  input wire logic [7:0] msg_vector,
  input wire logic present
);
  logic [19:0] since_init_q;
  logic [19:0] since_start_q;
  logic done_q;
  logic is_init;
  logic is_start;

  assign is_init = msg_valid && (msg_kind == msm_pkg::MSM_MSG_INIT);
  assign is_start = msg_valid && (msg_kind == msm_pkg::MSM_MSG_STARTUP);

  // ----
  // cycles since the last init and the last startup, saturating
  // ----
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_init_q <= 20'hf_ffff;
    end else if (is_init) begin
      since_init_q <= 20'h0_0000;
    end else if (since_init_q != 20'hf_ffff) begin
      since_init_q <= since_init_q + 20'h0_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || is_init) begin
      since_start_q <= 20'hf_ffff;
    end else if (is_start) begin
      since_start_q <= 20'h0_0000;
    end else if (since_start_q != 20'hf_ffff) begin
      since_start_q <= since_start_q + 20'h0_0001;
    end
  end

  // peers have reported since the last init
  always_ff @(posedge clk_i) begin
    if (rst_i || is_init) begin
      done_q <= 1'b0;
    end else if (present) begin
      done_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_valid_pulse;
    msg_valid |=> !msg_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("message strobe longer than one cycle");

  property p_msg_hold;
    !msg_valid |-> $stable(msg_kind) && $stable(msg_vector);
  endproperty
  a_msg_hold: assert property (p_msg_hold)
    else $error("message fields changed without a strobe");

  property p_init_gap;
    is_start |-> since_init_q >= INIT_GAP - 1;
  endproperty
  a_init_gap: assert property (p_init_gap)
    else $error("startup sent too soon after init");

  property p_start_gap;
    is_start |-> since_start_q >= 20'h0_07cf;
  endproperty
  a_start_gap: assert property (p_start_gap)
    else $error("startup sent too soon after startup");

  property p_present_pulse;
    present |=> !present;
  endproperty
  a_present_pulse: assert property (p_present_pulse)
    else $error("presence pulse longer than one cycle");

  property p_present_window;
    present |-> since_start_q inside {[3:16]};
  endproperty
  a_present_window: assert property (p_present_window)
    else $error("presence outside the window after startup");

  property p_halted_stay;
    is_start && done_q |=> !present [*8];
  endproperty
  a_halted_stay: assert property (p_halted_stay)
    else $error("halted peer woke on startup");

  property p_init_quiet;
    is_init |=> !present [*4];
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("presence right after init");
endmodule : msm_link_asserts

// ### tb/msm_tb_top.sv
// self-checking bench: local unit and peers joined over the message link
`timescale 1ns/1ps
module msm_tb_top;
  logic clk_i, rst_i, cyc, stb, we, mode, thr;
  logic [31:0] adr, wdat, rdat, sts, wb_dat_o, leaf11, model_id;
  logic [3:0] sel;
  logic [1:0] pkg, clu, pkg_f, clu_f, running, halted, uncached;
  logic [7:0] vv, ev, id, leaf1, err_vec;
  logic wb_ack_o, unit_en, thr_f;
  logic [1:0][19:0] fetch;
  logic [1:0][31:0] smm;
  int errors, compares, n_init, n_start;

  msm_link_if link ();

  msm_local_unit #(.INIT_GAP_CYC(50), .PRESENCE_CYC(200)) i_msm_local_unit (.clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .strap_package_i(pkg), .strap_cluster_i(clu), .strap_thread_i(thr),
    .reg_iface_mode_i(mode), .unit_enabled_o(unit_en), .error_vector_o(err_vec),
    .ident_leaf1_id_o(leaf1), .ident_leaf11_id_o(leaf11), .model_reg_id_o(model_id),
    .pkg_field_o(pkg_f), .cluster_field_o(clu_f), .thread_field_o(thr_f), .link(link));

  msm_peer_procs #(.NUM_AP(2)) i_msm_peer_procs (.clk_i(clk_i), .rst_i(rst_i),
    .link(link), .running_o(running), .halted_o(halted), .uncached_map_o(uncached),
    .fetch_addr_o(fetch), .smm_base_o(smm));

  msm_link_asserts #(.INIT_GAP(50)) i_msm_link_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .msg_valid(link.msg_valid), .msg_kind(link.msg_kind),
    .msg_vector(link.msg_vector), .present(link.present));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (link.msg_valid === 1'b1 && link.msg_kind === msm_pkg::MSM_MSG_INIT) n_init++;
    if (link.msg_valid === 1'b1 && link.msg_kind === msm_pkg::MSM_MSG_STARTUP) n_start++;
  end

  // ----
  // shared tasks
  // ----
  task automatic print_verdict();
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] rd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wait_start(input int k);
    int n;
    n = 0;
    while (n_start < k && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n_start < k) errors++;
    repeat (20) @(posedge clk_i);
  endtask : wait_start

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    print_verdict();
  end

  // ----
  // main sequence
  // ----
  initial begin
    errors = 0;
    compares = 0;
    n_init = 0;
    n_start = 0;
    void'($urandom(32'hf5a2));
    {clu, pkg, thr} = 5'($urandom);
    {rst_i, mode, cyc, stb, we} = 5'b11000;
    adr = 32'h0000_0000;
    wdat = 32'h0000_0000;
    sel = 4'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    id = {3'b000, clu, pkg, thr};
    chk({24'h0, leaf1}, {24'h0, id});
    chk(leaf11, {24'h0, id});
    chk(model_id, {24'h0, id});
    chk({27'h0, clu_f, pkg_f, thr_f}, {27'h0, clu, pkg, thr});
    mode <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(model_id, 32'h0000_0000);
    wb(1'b0, msm_pkg::ADR_PROC_ID, 32'h0, 4'hf, rdat);
    chk(rdat & msm_pkg::ID_BYTE_MASK, {id, 24'h0});
    wb(1'b0, msm_pkg::ADR_SPUR_VEC, 32'h0, 4'hf, rdat);
    chk(rdat, msm_pkg::RST_SPUR_VEC);
    wb(1'b1, msm_pkg::ADR_CMD_LOW, 32'h000c_4500, 4'hf, rdat);
    repeat (3) @(posedge clk_i);
    chk(32'(n_init), 32'h0);
    wb(1'b1, msm_pkg::ADR_SPUR_VEC, 32'h0000_0100, 4'hf, rdat);
    chk({31'h0, unit_en}, 32'h1);
    sts = $urandom;
    ev = 8'($urandom);
    wb(1'b1, msm_pkg::ADR_ERR_VEC, sts, 4'hf, rdat);
    wb(1'b1, msm_pkg::ADR_ERR_VEC, {24'h0, ev}, 4'h1, rdat);
    wb(1'b0, msm_pkg::ADR_ERR_VEC, 32'h0, 4'hf, rdat);
    chk(rdat, {sts[31:8], ev});
    chk({24'h0, err_vec}, {24'h0, ev});
    wb(1'b1, 32'hfee0_0400, sts, 4'hf, rdat);
    wb(1'b0, 32'hfee0_0400, 32'h0, 4'hf, rdat);
    chk(rdat, 32'h0000_0000);
    for (int r = 0; r < 2; r++) begin
      vv = 8'($urandom);
      wb(1'b1, msm_pkg::ADR_CMD_LOW, 32'h000c_4500, 4'hf, rdat);
      chk(32'(n_init), 32'(r + 1));
      wb(1'b1, msm_pkg::ADR_CMD_LOW, {msm_pkg::CMD_START_HI, vv}, 4'hf, rdat);
      wb(1'b0, msm_pkg::ADR_BOOT_STAT, 32'h0, 4'hf, rdat);
      chk(rdat, 32'h0000_0501);
      wait_start(2 * r + 1);
      chk({24'h0, link.msg_vector}, {24'h0, vv});
      chk({12'h0, fetch[0]}, {12'h0, vv, 12'h000});
      chk({12'h0, fetch[1]}, {12'h0, vv, 12'h000});
      chk({28'h0, halted, uncached}, 32'h0000_000f);
      chk(smm[1] - smm[0], msm_pkg::SMM_STRIDE);
      wb(1'b0, msm_pkg::ADR_BOOT_STAT, 32'h0, 4'hf, rdat);
      chk(rdat & 32'h0000_00ff, 32'h0000_0003);
      wb(1'b1, msm_pkg::ADR_CMD_LOW, {msm_pkg::CMD_START_HI, ~vv}, 4'hf, rdat);
      wb(1'b0, msm_pkg::ADR_BOOT_STAT, 32'h0, 4'hf, rdat);
      chk({31'h0, rdat[8]}, 32'h1);
      wait_start(2 * r + 2);
      chk(32'(n_start), 32'(2 * r + 2));
      chk({12'h0, fetch[0]}, {12'h0, vv, 12'h000});
      chk({30'h0, halted}, 32'h3);
    end
    wb(1'b1, msm_pkg::ADR_CMD_LOW, 32'h000c_4500, 4'hf, rdat);
    repeat (5) @(posedge clk_i);
    chk({28'h0, running, halted}, 32'h0);
    repeat (250) @(posedge clk_i);
    wb(1'b0, msm_pkg::ADR_BOOT_STAT, 32'h0, 4'hf, rdat);
    chk(rdat, 32'h0000_0201);
    print_verdict();
  end
endmodule : msm_tb_top
